// File: include/spdl_pkg.sv
// Operation
// (R1) Shift data on each serial clock rise
// (R2) Last bit shifted selects destination latch
// (R3) Selector high plus strobe loads reference latch
// (R4) Selector low plus strobe loads main latch
// (R5) Floating strobe reads high, loads latch
// (R6) Reference path: 16 shift, 15 latch, 14 counter
// (R7) Prescaler bit high 64/65, low 128/129
// (R8) Reference ratio binary, range 8 to 16383
// (R9) Host sets selector high for reference word
// (R10) Seven-bit swallow counter, values 0 to 127
// (R11) Eleven-bit programmable counter, 16 to 2047
// (R12) Lock output high when locked, else low
// (R13) Polarity low inverts pump and detector outputs
// (R14) Reference monitor mirrors reference divider output
// (R15) Divider monitor mirrors programmable divider output
// (R16) Main path: 19 shift, 18 latch, counters
// (R17) Pump high when reference faster, Z equal
// (R18) Host shifts selector last, strobe after clock
// (R19) Counters reload only from latched words
package spdl_pkg;
  localparam int REF_SHIFT_W  = 16;
  localparam int REF_LATCH_W  = 15;
  localparam int REF_CNT_W    = 14;
  localparam int MAIN_SHIFT_W = 19;
  localparam int MAIN_LATCH_W = 18;
  localparam int SWAL_W       = 7;
  localparam int PROG_W       = 11;
  localparam int REF_CNT_LSB  = 0;
  localparam int REF_PRE_POS  = 14;
  localparam int SWAL_LSB     = 0;
  localparam int PROG_LSB     = 7;
  localparam logic [13:0] REF_RATIO_RST  = 14'h0008;
  localparam logic [10:0] PROG_RATIO_RST = 11'h010;
  localparam logic [6:0]  SWAL_RATIO_RST = 7'h00;
  localparam int PRE_SMALL = 64;
  localparam int PRE_LARGE = 128;
  localparam int LOCK_CYCLES = 3;
  localparam int LOCK_W = 2;
endpackage

// File: logic/spdl_sync.sv
module spdl_sync (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic s1_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule

// File: logic/spdl_divider.sv
module spdl_divider #(
  parameter int W = 14
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] ratio,
  output logic              pulse
);
  logic [W-1:0] cnt_q;
  // Divide-by-ratio; ratio is sampled only at terminal count
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= '0;
      pulse <= 1'b0;
    end else if (tick) begin
      if (cnt_q <= W'(1)) begin
        cnt_q <= ratio;
        pulse <= 1'b1;
      end else begin
        cnt_q <= cnt_q - W'(1);
        pulse <= 1'b0;
      end
    end else begin
      pulse <= 1'b0;
    end
  end
endmodule

// File: logic/spdl_top.sv
module spdl_top
  import spdl_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         sys_rst,
  input  wire logic                         ser_clk,
  input  wire logic                         ser_data,
  input  wire logic                         load_strobe,
  input  wire logic                         load_strobe_oe,
  input  wire logic                         phase_polarity_select,
  input  wire logic                         phase_polarity_select_oe,
  input  wire logic                         crystal_input,
  input  wire logic                         rf_input,
  output logic                              pump_out,
  output logic                              pump_oe,
  output logic                              det_ref_out,
  output logic                              det_div_out,
  output logic                              det_div_oe,
  output logic                              lock_indicator_out,
  output logic                              reference_compare_monitor,
  output logic                              divider_compare_monitor,
  output logic [spdl_pkg::REF_CNT_W-1:0]    ref_ratio,
  output logic                              prescaler_modulus_select,
  output logic [spdl_pkg::SWAL_W-1:0]       swallow_ratio,
  output logic [spdl_pkg::PROG_W-1:0]       prog_ratio
);
  import spdl_pkg::*;

  // Link domain: shift registers on the serial clock
  logic [REF_SHIFT_W-1:0]  ref_sh_q;
  logic [MAIN_SHIFT_W-1:0] main_sh_q;
  always_ff @(posedge ser_clk) begin
    ref_sh_q  <= {ref_sh_q[REF_SHIFT_W-2:0], ser_data}; // R1 R6
    main_sh_q <= {main_sh_q[MAIN_SHIFT_W-2:0], ser_data}; // R1 R16
  end

  // Strobe and polarity pins with pull-ups: undriven reads high
  function automatic logic pulled_up(input logic oe, input logic lvl);
    return oe ? lvl : 1'b1;
  endfunction

  // Polarity high picks the first source, low the second
  function automatic logic pol_pick(input logic pol, input logic hi_src, input logic lo_src);
    return pol ? hi_src : lo_src;
  endfunction

  logic strobe_pin;
  logic pol_pin;
  assign strobe_pin = pulled_up(load_strobe_oe, load_strobe); // R5
  assign pol_pin = pulled_up(phase_polarity_select_oe, phase_polarity_select); // R13

  logic strobe_s;
  logic pol_s;
  logic crys_s;
  logic rf_s;
  spdl_sync u_sync_strobe (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (strobe_pin),
    .q       (strobe_s)
  );
  spdl_sync u_sync_pol (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (pol_pin),
    .q       (pol_s)
  );
  spdl_sync u_sync_xt (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (crystal_input),
    .q       (crys_s)
  );
  spdl_sync u_sync_rf (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       (rf_input),
    .q       (rf_s)
  );

  // Strobe rising edge captures shift words; host holds serial clock still (R18)
  logic strobe_d1_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) strobe_d1_q <= 1'b0;
    else strobe_d1_q <= strobe_s;
  end
  logic load_ev;
  assign load_ev = strobe_s & ~strobe_d1_q;

  // Word captured while the serial clock is quiet; selector is the last bit
  logic [REF_LATCH_W-1:0]  ref_latch_q;
  logic [MAIN_LATCH_W-1:0] main_latch_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_latch_q <= {1'b1, REF_RATIO_RST};
    end else if (load_ev && ref_sh_q[0]) begin // R2 R3 R9
      ref_latch_q <= ref_sh_q[REF_SHIFT_W-1:1];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      main_latch_q <= {PROG_RATIO_RST, SWAL_RATIO_RST};
    end else if (load_ev && !main_sh_q[0]) begin // R2 R4
      main_latch_q <= main_sh_q[MAIN_SHIFT_W-1:1];
    end
  end

  assign ref_ratio = ref_latch_q[REF_CNT_LSB +: REF_CNT_W]; // R8
  assign prescaler_modulus_select = ref_latch_q[REF_PRE_POS]; // R7
  assign swallow_ratio = main_latch_q[SWAL_LSB +: SWAL_W]; // R10
  assign prog_ratio = main_latch_q[PROG_LSB +: PROG_W]; // R11

  // Edge ticks of the crystal and VCO inputs
  logic crys_d_q;
  logic rf_d_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      crys_d_q <= 1'b0;
      rf_d_q   <= 1'b0;
    end else begin
      crys_d_q <= crys_s;
      rf_d_q   <= rf_s;
    end
  end
  logic crys_tick;
  logic rf_tick;
  assign crys_tick = crys_s & ~crys_d_q;
  assign rf_tick = rf_s & ~rf_d_q;

  // Dual-modulus prescaler, modulus P or P+1 chosen by swallow phase
  logic [7:0] pre_cnt_q;
  logic [7:0] pre_mod;
  logic       swallow_busy;
  logic       pre_tick;
  always_comb begin
    pre_mod = prescaler_modulus_select ? 8'(PRE_SMALL) : 8'(PRE_LARGE); // R7
    if (swallow_busy) pre_mod = pre_mod + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_cnt_q <= 8'h00;
      pre_tick  <= 1'b0;
    end else if (rf_tick) begin
      if (pre_cnt_q + 8'h01 >= pre_mod) begin
        pre_cnt_q <= 8'h00;
        pre_tick  <= 1'b1;
      end else begin
        pre_cnt_q <= pre_cnt_q + 8'h01;
        pre_tick  <= 1'b0;
      end
    end else begin
      pre_tick <= 1'b0;
    end
  end

  // Swallow and programmable counters reload only from the latch
  logic [SWAL_W-1:0] swal_q;
  logic [PROG_W-1:0] prog_q;
  logic              div_pulse;
  assign swallow_busy = swal_q != '0;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      swal_q    <= SWAL_RATIO_RST;
      prog_q    <= PROG_RATIO_RST;
      div_pulse <= 1'b0;
    end else if (pre_tick) begin
      if (prog_q <= PROG_W'(1)) begin
        prog_q    <= prog_ratio; // R19
        swal_q    <= swallow_ratio; // R19
        div_pulse <= 1'b1;
      end else begin
        prog_q    <= prog_q - PROG_W'(1);
        if (swallow_busy) swal_q <= swal_q - SWAL_W'(1);
        div_pulse <= 1'b0;
      end
    end else begin
      div_pulse <= 1'b0;
    end
  end

  logic ref_pulse;
  spdl_divider #(.W(REF_CNT_W)) u_ref_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tick(crys_tick),
    .ratio(ref_ratio), // R19
    .pulse(ref_pulse)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reference_compare_monitor <= 1'b0;
      divider_compare_monitor   <= 1'b0;
    end else begin
      reference_compare_monitor <= ref_pulse; // R14
      divider_compare_monitor   <= div_pulse; // R15
    end
  end

  // Phase-frequency detector
  logic up_q;
  logic dn_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if ((up_q | ref_pulse) && (dn_q | div_pulse)) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_q | ref_pulse;
      dn_q <= dn_q | div_pulse;
    end
  end

  // Pump: with polarity high, high for reference ahead, low for behind (polarity low swaps these); Z when equal
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pump_out    <= 1'b0;
      pump_oe     <= 1'b0;
      det_ref_out <= 1'b0;
      det_div_out <= 1'b0;
      det_div_oe  <= 1'b0;
    end else begin
      pump_oe     <= up_q ^ dn_q; // R17
      pump_out    <= pol_pick(pol_s, up_q, dn_q); // R13 R17
      det_ref_out <= pol_pick(pol_s, dn_q, up_q); // R13
      det_div_out <= 1'b0;
      det_div_oe  <= pol_pick(pol_s, up_q, dn_q); // R13
    end
  end

  // Lock: error resets, quiet comparisons count up to three
  logic [LOCK_W-1:0] lock_cnt_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_cnt_q         <= '0;
      lock_indicator_out <= 1'b0;
    end else if (up_q ^ dn_q) begin
      lock_cnt_q         <= '0;
      lock_indicator_out <= 1'b0; // R12
    end else if (ref_pulse && div_pulse) begin
      if (lock_cnt_q == LOCK_W'(LOCK_CYCLES)) begin
        lock_indicator_out <= 1'b1; // R12
      end else begin
        lock_cnt_q <= lock_cnt_q + LOCK_W'(1);
      end
    end
  end
endmodule

// File: testbench/spdl_top_props.sv
module spdl_top_props
  import spdl_pkg::*;
(
  input wire logic                           clk_sys,
  input wire logic                           sys_rst,
  input wire logic                           load_strobe,
  input wire logic                           load_strobe_oe,
  input wire logic                           det_div_out,
  input wire logic                           pump_oe,
  input wire logic                           lock_indicator_out,
  input wire logic                           reference_compare_monitor,
  input wire logic                           divider_compare_monitor,
  input wire logic [spdl_pkg::REF_CNT_W-1:0] ref_ratio,
  input wire logic                           prescaler_modulus_select,
  input wire logic [spdl_pkg::SWAL_W-1:0]    swallow_ratio,
  input wire logic [spdl_pkg::PROG_W-1:0]    prog_ratio
);
  timeunit 1ns;
  timeprecision 100ps;
  logic strobe_hi;
  assign strobe_hi = load_strobe | ~load_strobe_oe;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_RST_VALUES: assert property ($fell(sys_rst) |-> ref_ratio == REF_RATIO_RST
    && prog_ratio == PROG_RATIO_RST && swallow_ratio == SWAL_RATIO_RST
    && prescaler_modulus_select) else $error("latch reset value wrong");
  AST_HOLD_NO_STROBE: assert property ((!strobe_hi)[*6] |-> $stable(ref_ratio)
    && $stable(prog_ratio) && $stable(swallow_ratio)) else $error("latch moved");
  AST_ONE_LATCH: assert property (!(($changed(ref_ratio) || $changed(prescaler_modulus_select))
    && ($changed(prog_ratio) || $changed(swallow_ratio)))) else $error("both latches moved");
  AST_MAIN_AFTER_STROBE: assert property ($changed(prog_ratio) |-> $past(strobe_hi, 2)
    || $past(strobe_hi, 3) || $past(strobe_hi, 4)) else $error("main load without strobe");
  AST_REF_MIN: assert property (ref_ratio >= 14'h0008)
    else $error("reference ratio below 8");
  AST_PROG_MIN: assert property (prog_ratio >= 11'h010)
    else $error("programmable ratio below 16");
  AST_REF_MON_PULSE: assert property (reference_compare_monitor |=> !reference_compare_monitor)
    else $error("reference monitor pulse too long");
  AST_DIV_MON_PULSE: assert property (divider_compare_monitor |=> !divider_compare_monitor)
    else $error("divider monitor pulse too long");
  AST_DIV_OPEN_DRAIN: assert property (!det_div_out)
    else $error("open drain driven high");
  AST_LOCK_CLEAR: assert property (pump_oe |-> !lock_indicator_out)
    else $error("lock high during phase error");
  cover property ($changed(ref_ratio));
  cover property ($changed(prog_ratio));
  cover property (reference_compare_monitor);
  cover property (divider_compare_monitor);
endmodule

bind spdl_top spdl_top_props spdl_top_props_i (.clk_sys, .sys_rst, .load_strobe, .load_strobe_oe,
  .det_div_out, .pump_oe, .lock_indicator_out, .reference_compare_monitor,
  .divider_compare_monitor, .ref_ratio,
  .prescaler_modulus_select, .swallow_ratio, .prog_ratio);

// File: testbench/spdl_host.sv
module spdl_host (
  input  wire logic clk_sys,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe,
  output logic      load_strobe_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    load_strobe = 1'h0;
    load_strobe_oe = 1'h1;
  end
  // Shift MSB first, selector last; link clock idles low between frames
  task automatic send(input logic [18:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      #12 ser_clk = 1'h1;
      #24 ser_clk = 1'h0;
      #12;
    end
    ser_data = ~ser_data;
  endtask
  // Strobe after the clock stands still; open pin reads high
  task automatic strobe(input logic open_pin);
    repeat (4) @(posedge clk_sys);
    #1 load_strobe = ~open_pin;
    load_strobe_oe = ~open_pin;
    repeat (8) @(posedge clk_sys);
    #1 load_strobe = 1'h0;
    load_strobe_oe = 1'h1;
  endtask
endmodule

// File: testbench/spdl_top_tb.sv
module spdl_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [18:0] w; int n; logic [13:0] r; logic p; logic [6:0] s; logic [10:0] g;}
    spdl_row_t;
  logic clk_sys = 1'h0, sys_rst = 1'h1, ser_clk, ser_data, load_strobe, load_strobe_oe;
  logic phase_polarity_select = 1'h1, phase_polarity_select_oe = 1'h0, crystal_input, rf_input;
  logic pump_out, pump_oe, det_ref_out, det_div_out, det_div_oe, lock_indicator_out;
  logic reference_compare_monitor, divider_compare_monitor, prescaler_modulus_select;
  logic [13:0] ref_ratio;
  logic [6:0]  swallow_ratio;
  logic [10:0] prog_ratio;
  logic [1:0]  ph = 2'h0;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, nr, nd;
  // Host ranges: ratio 8..16383, swallow 0..127, prog 16..2047
  spdl_row_t   rows [5] = '{'{19'h07FFF, 16, 14'h3FFF, 1'h0, 7'h00, 11'h010},
    '{19'h7FFFE, 19, 14'h3FFF, 1'h0, 7'h7F, 11'h7FF}, '{19'h089A5, 16, 14'h04D2, 1'h1, 7'h7F,
    11'h7FF}, '{19'h01000, 19, 14'h04D2, 1'h1, 7'h00, 11'h010}, '{19'h08011, 16, 14'h0008, 1'h1,
    7'h00, 11'h010}};
  spdl_top spdl_top_i (.clk_sys, .sys_rst, .ser_clk, .ser_data, .load_strobe, .load_strobe_oe,
    .phase_polarity_select, .phase_polarity_select_oe, .crystal_input, .rf_input, .pump_out,
    .pump_oe, .det_ref_out, .det_div_out, .det_div_oe, .lock_indicator_out,
    .reference_compare_monitor, .divider_compare_monitor, .ref_ratio, .prescaler_modulus_select,
    .swallow_ratio, .prog_ratio);
  spdl_host spdl_host_i (.clk_sys, .ser_clk, .ser_data, .load_strobe, .load_strobe_oe);
  assign crystal_input = ph[1];
  assign rf_input = ph[0];
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    #1 ph <= ph + 2'h1;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic chk_all(input logic [13:0] r, input logic p, input logic [6:0] s,
                         input logic [10:0] g);
    chk("ref_ratio", r, ref_ratio);
    chk("prescaler", {13'h0000, p}, {13'h0000, prescaler_modulus_select});
    chk("swallow", {7'h00, s}, {7'h00, swallow_ratio});
    chk("prog", {3'h0, g}, {3'h0, prog_ratio});
  endtask
  task automatic end_sim();
    $display("cmp_count %0d error_cnt %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'h0;
    repeat (3) @(posedge clk_sys);
    chk_all(14'h0008, 1'h1, 7'h00, 11'h010);
    foreach (rows[i]) begin
      spdl_host_i.send(rows[i].w, rows[i].n);
      spdl_host_i.strobe(1'h0);
      chk_all(rows[i].r, rows[i].p, rows[i].s, rows[i].g);
    end
    spdl_host_i.send(19'h7FFFE, 19);
    spdl_host_i.strobe(1'h1);
    chk_all(14'h0008, 1'h1, 7'h7F, 11'h7FF);
    #1 sys_rst = 1'h1;
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 1'h0;
    phase_polarity_select_oe = 1'h1;
    phase_polarity_select = 1'h0;
    repeat (2) @(posedge clk_sys);
    chk_all(14'h0008, 1'h1, 7'h00, 11'h010);
    nr = 0;
    nd = 0;
    repeat (4200) begin
      @(posedge clk_sys);
      #2 nr += reference_compare_monitor;
      nd += divider_compare_monitor;
    end
    chk("ref_pulses", 14'h0001, {13'h0000, nr >= 130 && nr <= 132});
    chk("div_pulses", 14'h0001, {13'h0000, nd >= 1 && nd <= 3});
    chk("pump_oe", 14'h0001, {13'h0000, pump_oe});
    chk("pump_out", 14'h0000, {13'h0000, pump_out});
    chk("det_ref_out", 14'h0001, {13'h0000, det_ref_out});
    chk("det_div_oe", 14'h0000, {13'h0000, det_div_oe});
    chk("lock", 14'h0000, {13'h0000, lock_indicator_out});
    @(posedge clk_sys);
    #1 phase_polarity_select_oe = 1'h0;
    repeat (6) @(posedge clk_sys);
    #2 chk("pump_out", 14'h0001, {13'h0000, pump_out});
    chk("det_ref_out", 14'h0000, {13'h0000, det_ref_out});
    chk("det_div_oe", 14'h0001, {13'h0000, det_div_oe});
    spdl_host_i.send(19'h00011, 16);
    spdl_host_i.strobe(1'h0);
    spdl_host_i.send(19'h01006, 19);
    spdl_host_i.strobe(1'h0);
    chk_all(14'h0008, 1'h0, 7'h03, 11'h010);
    nr = 0;
    nd = 0;
    while (nd < 2) begin
      @(posedge clk_sys);
      #2 nr += (nd == 1);
      nd += divider_compare_monitor;
    end
    chk("div_period", 14'h1006, 14'(nr));
    end_sim();
  end
endmodule
